// ==== testbench.sv ====
// self-checking bench for the usb identity and pin settings bank
// assumes the apb slave answers with its own pready; host model only observes
`timescale 1ns/1ns
module testbench;
   import usb_identity_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   apb_req_s    req = '0;
   apb_rsp_s    rsp;
   logic        suspend_in = 1'b0;
   logic        rx_activity_in = 1'b0;
   logic [3:0]  pin_in = 4'hA;
   pin_drive_s  pin_drive;
   enum_info_s  enum_info;
   logic [15:0] seen_vendor;
   logic [15:0] seen_product;
   logic [7:0]  seen_attr;
   logic [9:0]  seen_max_ma;
   logic [31:0] rd;
   logic        err;
   int          failures = 0;
   int          cmp_count = 0;

   always #4 clk_sys = ~clk_sys;

   usb_identity_and_gp0_settings u_usb_identity_and_gp0_settings (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
      .apb_rsp(rsp), .suspend_in(suspend_in), .rx_activity_in(rx_activity_in), .pin_in(pin_in),
      .pin_drive(pin_drive), .enum_info(enum_info));
   usb_host_model u_usb_host_model (.clk_sys(clk_sys), .enum_info(enum_info), .seen_vendor(seen_vendor),
      .seen_product(seen_product), .seen_attr(seen_attr), .seen_max_ma(seen_max_ma));

   task automatic end_of_test;
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask : check

   // one apb transfer; request held until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: {24'h0, wd}};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      @(posedge clk_sys);
      while (rsp.pready !== 1'b1 && n < 16)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 16)
      begin
         failures++;
         end_of_test();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge clk_sys);
   endtask : xfer

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      check(48'({err, rd}), 48'({1'b0, 24'h0, exp}));
   endtask : rchk

   task automatic do_reset;
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check(48'(pin_drive.oe), 48'h0);
      repeat (12) @(posedge clk_sys);
   endtask : do_reset

   task automatic t_reset_values;
      logic [7:0] exp [0:9];
      exp = '{PIN0_RESET, PINX_RESET, PINX_RESET, PINX_RESET, VID_LOW_RESET, VID_HIGH_RESET, PID_LOW_RESET,
              PID_HIGH_RESET, PWR_ATTR_RESET, CURRENT_RESET};
      for (int i = 0; i < 10; i++)
         rchk(8'(i), exp[i]);
      for (int i = 0; i < NUM_SECRETS; i++)
         rchk(IDX_SECRET_BASE + 8'(i), SECRET_RESET);
      check(48'(enum_info), 48'({VID_HIGH_RESET, VID_LOW_RESET, PID_HIGH_RESET, PID_LOW_RESET, 2'b00,
                                 CURRENT_RESET}));
      check(48'(seen_max_ma), 48'h64);
      xfer(1'b0, IDX_PIN_STATUS, 8'h00);
      check(48'(rd), 48'h1A2);
   endtask : t_reset_values

   task automatic t_identity;
      logic [7:0] pwr [0:3];
      pwr = '{8'h80, 8'hC0, 8'hA0, 8'hE0};
      xfer(1'b1, IDX_VID_LOW, 8'hA5);
      xfer(1'b1, IDX_VID_HIGH, 8'h3C);
      xfer(1'b1, IDX_PID_LOW, 8'h0F);
      xfer(1'b1, IDX_PID_HIGH, 8'hF0);
      xfer(1'b1, IDX_CURRENT_REQ, 8'hFF);
      repeat (3) @(posedge clk_sys);
      check(48'({seen_vendor, seen_product, seen_max_ma}), 48'({16'h3CA5, 16'hF00F, 10'h1FE}));
      xfer(1'b0, IDX_ENUM_STATUS, 8'h00);
      check(48'(rd), 48'hF00F_3CA5);
      rchk(IDX_PID_HIGH, 8'hF0);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, IDX_POWER_ATTR, pwr[i]);
         repeat (3) @(posedge clk_sys);
         check(48'(seen_attr), 48'(pwr[i]));
      end
   endtask : t_identity

   task automatic t_pins;
      // {setting, suspend, rx activity, oe, out}; settings keep bits 7-5 clear
      logic [11:0] tab [0:6];
      tab = '{12'h103, 12'h002, 12'h080, 12'h01B, 12'h012, 12'h027, 12'h022};
      for (int i = 0; i < 7; i++)
      begin
         suspend_in <= tab[i][3];
         rx_activity_in <= tab[i][2];
         xfer(1'b1, IDX_PIN0, tab[i][11:4]);
         repeat (6) @(posedge clk_sys);
         check(48'({pin_drive.oe[0], pin_drive.oe[0] & pin_drive.out[0]}), 48'(tab[i][1:0]));
      end
      for (int c = 3; c < 8; c++)
      begin
         xfer(1'b1, IDX_PIN0, 8'(c));
         repeat (3) @(posedge clk_sys);
         check(48'(pin_drive.oe[0]), 48'h0);
      end
      rchk(IDX_PIN0, 8'h07);
      xfer(1'b1, IDX_PIN1, 8'h15);
      rchk(IDX_PIN1, 8'h15);
   endtask : t_pins

   task automatic t_reload;
      xfer(1'b1, IDX_PIN0, 8'h00);
      rx_activity_in <= 1'b1;
      xfer(1'b1, IDX_CONTROL, 8'h01);
      repeat (10) @(posedge clk_sys);
      rchk(IDX_PIN0, PIN0_RESET);
      check(48'({pin_drive.oe[0], pin_drive.out[0]}), 48'h3);
      xfer(1'b1, IDX_NV_PIN_BASE, 8'h00);
      rchk(IDX_NV_PIN_BASE, 8'h00);
      rchk(IDX_PIN0, PIN0_RESET);
      check(48'({pin_drive.oe[0], pin_drive.out[0]}), 48'h3);
      xfer(1'b1, IDX_CONTROL, 8'h01);
      repeat (10) @(posedge clk_sys);
      rchk(IDX_PIN0, 8'h00);
      check(48'({pin_drive.oe[0], pin_drive.out[0]}), 48'h2);
   endtask : t_reload

   task automatic t_secrets;
      xfer(1'b1, 8'h30, 8'h55);
      check(48'({err, rd}), 48'({1'b1, 32'h0}));
      for (int i = 0; i < NUM_SECRETS; i++)
         xfer(1'b1, IDX_SECRET_BASE + 8'(i), 8'hE0 + 8'(i));
      for (int i = 0; i < NUM_SECRETS; i++)
         rchk(IDX_SECRET_BASE + 8'(i), 8'hE0 + 8'(i));
   endtask : t_secrets

   initial
   begin
      do_reset();
      t_reset_values();
      t_identity();
      t_pins();
      t_reload();
      t_secrets();
      do_reset();
      rchk(IDX_VID_LOW, VID_LOW_RESET);
      end_of_test();
   end
endmodule : testbench

// ==== usb_host_model.sv ====
// enumerating host: records the descriptor fields the device reports
// assumes enum_info is stable between register writes
`timescale 1ns/1ns
module usb_host_model
   import usb_identity_pkg::*;
(
   // clock and device view
   input  wire logic       clk_sys,
   input  wire enum_info_s enum_info,
   // descriptor as recorded
   output logic [15:0]     seen_vendor,
   output logic [15:0]     seen_product,
   output logic [7:0]      seen_attr,
   output logic [9:0]      seen_max_ma
);
   always_ff @(posedge clk_sys)
   begin
      seen_vendor  <= enum_info.vendor_id;
      seen_product <= enum_info.product_id;
      seen_attr    <= {1'b1, enum_info.self_supplied_flag, enum_info.host_wake_capable, 5'h00};
      seen_max_ma  <= {1'b0, enum_info.bus_current_request, 1'b0};
   end
endmodule : usb_host_model

// ==== usb_identity_and_gp0_settings.sv ====
// usb identity, power attributes, secret bytes and pin settings bank behind apb
// assumes single clock; pin inputs are asynchronous and synchronised here
//
// Operation
// R1: power attribute bit 6 set reports self-powered, clear reports bus-powered.
// R2: power attribute bit 5 set reports remote wake-up capability.
// R3: eight-bit current request in 2 mA steps, reset value fifty.
// R4: software keeps power attribute bit 7 one and bits 4-0 zero.
// R5: vendor id held as low and high bytes, joined for enumeration.
// R6: product id held as low and high bytes, joined for enumeration.
// R7: eight writable secret bytes, each reset to zero.
// R8: pin settings kept nonvolatile, loaded into working copy; both writable.
// R9: working copy writes take effect at once on pin function.
// R10: nonvolatile copy sets power-up pin behaviour; edits wait for next load.
// R11: one settings byte per pin at indices zero to three.
// R12: pin zero level bit drives high or low in general output mode.
// R13: pin zero direction bit set means input, clear means output.
// R14: function codes general, suspend, rx led; others reserved.
// R15: software keeps settings bits 7-5 at zero.
// R16: pins stay released until the working copy is loaded after reset.
// R17: reserved function code keeps the pin high-impedance.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module usb_identity_and_gp0_settings
   import usb_identity_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // apb slave
   input  wire apb_req_s   apb_req,
   output apb_rsp_s        apb_rsp,
   // activity sources for alternate pin functions
   input  wire logic       suspend_in,
   input  wire logic       rx_activity_in,
   // pin zero pad and the other pads' levels
   input  wire logic [3:0] pin_in,
   output pin_drive_s      pin_drive,
   // enumeration values
   output enum_info_s      enum_info
);

   typedef struct packed {
      logic [7:0]          vid_low;
      logic [7:0]          vid_high;
      logic [7:0]          pid_low;
      logic [7:0]          pid_high;
      logic [7:0]          power_attr;
      logic [7:0]          current_req;
      logic [63:0]         secret;
      logic [31:0]         pin_work;
      logic [31:0]         pin_nv;
      load_state_e         load;
      logic [1:0]          load_idx;
      logic [3:0]          pin_sync1;
      logic [3:0]          pin_sync2;
      logic [1:0]          aux_sync1;
      logic [1:0]          aux_sync2;
      apb_rsp_s            rsp;
      pin_drive_s          drive;
      enum_info_s          info;
   } state_s;

   state_s s_q;
   state_s s_d;

   function automatic logic [7:0] pin_byte(input logic [31:0] v, input logic [1:0] i);
      pin_byte = v[8*i +: 8];
   endfunction : pin_byte

   // reserved codes read as not a valid designation
   function automatic logic func_valid(input logic [7:0] b);
      func_valid = (b[2:0] == FUNC_GENERAL) || (b[2:0] == FUNC_SUSPEND) || (b[2:0] == FUNC_RX_LED);
   endfunction : func_valid

   function automatic logic [7:0] word_index(input logic [11:0] a);
      word_index = {2'h0, a[7:2]};
   endfunction : word_index

   function automatic logic is_secret(input logic [7:0] i);
      is_secret = (i >= IDX_SECRET_BASE) && (i < IDX_SECRET_BASE + 8'(NUM_SECRETS));
   endfunction : is_secret

   logic       wr_en;
   logic       setup_ph;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [7:0] pin_wbyte;
   logic [7:0] pb;
   logic [31:0] rdata;
   logic       hit;

   always_comb
   begin
      s_d = s_q;
      // answer decoded in setup and registered, so it stands in the access cycle
      wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
      setup_ph = apb_req.psel && !apb_req.penable;
      idx = word_index(apb_req.paddr);
      wbyte = apb_req.pwdata[7:0];
      // reserved upper bits cannot be set by software
      pin_wbyte = wbyte & PIN_WRITE_MASK;                              // see R15
      rdata = 32'h0000_0000;
      hit = hit_addr(apb_req.paddr);
      pb = 8'h00;

      s_d.pin_sync1 = pin_in;
      s_d.pin_sync2 = s_q.pin_sync1;
      s_d.aux_sync1 = {suspend_in, rx_activity_in};
      s_d.aux_sync2 = s_q.aux_sync1;

      unique case (idx)
         IDX_PIN0, IDX_PIN1, IDX_PIN2, IDX_PIN3:
            rdata[7:0] = pin_byte(s_q.pin_work, idx[1:0]);                // see R11
         IDX_VID_LOW:     rdata[7:0] = s_q.vid_low;
         IDX_VID_HIGH:    rdata[7:0] = s_q.vid_high;
         IDX_PID_LOW:     rdata[7:0] = s_q.pid_low;
         IDX_PID_HIGH:    rdata[7:0] = s_q.pid_high;
         IDX_POWER_ATTR:  rdata[7:0] = s_q.power_attr;
         IDX_CURRENT_REQ: rdata[7:0] = s_q.current_req;
         IDX_NV_PIN_BASE, IDX_NV_PIN_BASE + 8'h01, IDX_NV_PIN_BASE + 8'h02, IDX_NV_PIN_BASE + 8'h03:
            rdata[7:0] = pin_byte(s_q.pin_nv, idx[1:0]);
         IDX_CONTROL:     rdata = 32'h0000_0000;
         IDX_ENUM_STATUS: rdata = {s_q.info.product_id, s_q.info.vendor_id};
         IDX_PIN_STATUS:  rdata = {20'h0_0000, s_q.drive.oe, s_q.pin_sync2, 2'h0,
                                   (s_q.load == LD_DONE), (s_q.load == LD_COPY)};
         default:
         begin
            if (is_secret(idx))
               rdata[7:0] = s_q.secret[8*(idx - IDX_SECRET_BASE) +: 8];
            else
               hit = 1'b0;
         end
      endcase

      if (wr_en && hit)
      begin
         unique case (idx)
            IDX_PIN0, IDX_PIN1, IDX_PIN2, IDX_PIN3:
               s_d.pin_work[8*idx[1:0] +: 8] = pin_wbyte;                   // see R8, R9
            IDX_VID_LOW:     s_d.vid_low = wbyte;                           // see R5
            IDX_VID_HIGH:    s_d.vid_high = wbyte;                          // see R5
            IDX_PID_LOW:     s_d.pid_low = wbyte;                           // see R6
            IDX_PID_HIGH:    s_d.pid_high = wbyte;                          // see R6
            IDX_POWER_ATTR:  s_d.power_attr = wbyte;
            IDX_CURRENT_REQ: s_d.current_req = wbyte;                       // see R3
            IDX_NV_PIN_BASE, IDX_NV_PIN_BASE + 8'h01, IDX_NV_PIN_BASE + 8'h02, IDX_NV_PIN_BASE + 8'h03:
               s_d.pin_nv[8*idx[1:0] +: 8] = pin_wbyte;                     // see R8, R10
            IDX_CONTROL:
               if (wbyte[CTRL_RELOAD_BIT] && s_q.load != LD_COPY)
               begin
                  s_d.load = LD_COPY;
                  s_d.load_idx = 2'h0;
               end
            default:
               if (is_secret(idx))
                  s_d.secret[8*(idx - IDX_SECRET_BASE) +: 8] = wbyte;       // see R7
         endcase
      end

      // copy nonvolatile image into working copy one byte per cycle
      unique case (s_q.load)
         LD_IDLE:
         begin
            s_d.load = LD_COPY;
            s_d.load_idx = 2'h0;
         end
         LD_COPY:
         begin
            s_d.pin_work[8*s_q.load_idx +: 8] = pin_byte(s_q.pin_nv, s_q.load_idx); // see R10
            s_d.load_idx = s_q.load_idx + 2'h1;
            if (s_q.load_idx == 2'(NUM_PINS - 1))
               s_d.load = LD_DONE;
         end
         LD_DONE: ;
      endcase

      s_d.rsp.pready = setup_ph;
      s_d.rsp.pslverr = setup_ph && !hit;
      s_d.rsp.prdata = (setup_ph && hit) ? rdata : 32'h0000_0000;

      // pin drive from the working copy; released until loaded
      s_d.drive.out = '0;
      s_d.drive.oe = '0;
      if (s_q.load == LD_DONE)                                              // see R16
      begin
         pb = pin_byte(s_q.pin_work, 2'h0);
         if (func_valid(pb))                                                // see R17
         begin
            unique case (pb[2:0])
               FUNC_GENERAL:                                                // see R14
               begin
                  s_d.drive.oe[0] = !pb[PIN_DIR_BIT];                       // see R13
                  s_d.drive.out[0] = pb[PIN_LEVEL_BIT];                     // see R12
               end
               FUNC_SUSPEND:
               begin
                  s_d.drive.oe[0] = 1'b1;
                  s_d.drive.out[0] = s_q.aux_sync2[1];                      // see R14
               end
               FUNC_RX_LED:
               begin
                  s_d.drive.oe[0] = 1'b1;
                  s_d.drive.out[0] = s_q.aux_sync2[0];                      // see R14
               end
               default: ;
            endcase
         end
      end

      s_d.info.vendor_id = {s_q.vid_high, s_q.vid_low};                     // see R5
      s_d.info.product_id = {s_q.pid_high, s_q.pid_low};                    // see R6
      s_d.info.self_supplied_flag = s_q.power_attr[PWR_SELF_BIT];           // see R1
      s_d.info.host_wake_capable = s_q.power_attr[PWR_WAKE_BIT];            // see R2
      s_d.info.bus_current_request = s_q.current_req;                       // see R3
   end

   // address decode used in setup phase for the registered answer
   function automatic logic hit_addr(input logic [11:0] a);
      logic [7:0] i;
      i = word_index(a);
      hit_addr = (a[11:8] == 4'h0) && ((i <= IDX_PIN_STATUS && i >= IDX_NV_PIN_BASE)
                 || (i < IDX_SECRET_BASE + 8'(NUM_SECRETS)));
   endfunction : hit_addr

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.vid_low <= VID_LOW_RESET;
         s_q.vid_high <= VID_HIGH_RESET;
         s_q.pid_low <= PID_LOW_RESET;
         s_q.pid_high <= PID_HIGH_RESET;
         s_q.power_attr <= PWR_ATTR_RESET;                                  // see R1, R2
         s_q.current_req <= CURRENT_RESET;                                  // see R3
         s_q.secret <= {NUM_SECRETS{SECRET_RESET}};                         // see R7
         // nonvolatile image survives in a real part; here it restarts at factory values
         s_q.pin_nv <= {PINX_RESET, PINX_RESET, PINX_RESET, PIN0_RESET};
         s_q.pin_work <= {PINX_RESET, PINX_RESET, PINX_RESET, PIN0_RESET};
         s_q.load <= LD_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign pin_drive = s_q.drive;
   assign enum_info = s_q.info;

endmodule : usb_identity_and_gp0_settings

// ==== usb_identity_monitor.sv ====
// checker for the usb identity and pin settings bank
// assumes zero-wait apb and enum outputs one cycle behind the registers
`timescale 1ns/1ns
module usb_identity_monitor
   import usb_identity_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst,
   // apb
   input wire apb_req_s   apb_req,
   input wire apb_rsp_s   apb_rsp,
   // pins and enumeration
   input wire logic       suspend_in,
   input wire logic       rx_activity_in,
   input wire logic [3:0] pin_in,
   input wire pin_drive_s pin_drive,
   input wire enum_info_s enum_info
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire       acc_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   wire [5:0] widx   = apb_req.paddr[7:2];
   wire [7:0] wbyte  = apb_req.pwdata[7:0];
   wire       pin0_wr = acc_wr && widx == IDX_PIN0[5:0];

   zero_wait_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
      else $error("no ready in access phase");
   self_flag_a: assert property (acc_wr && widx == IDX_POWER_ATTR[5:0]
      |=> ##1 enum_info.self_supplied_flag == $past(wbyte[6], 2)) else $error("self flag wrong");
   wake_flag_a: assert property (acc_wr && widx == IDX_POWER_ATTR[5:0]
      |=> ##1 enum_info.host_wake_capable == $past(wbyte[5], 2)) else $error("wake flag wrong");
   current_req_a: assert property (acc_wr && widx == IDX_CURRENT_REQ[5:0]
      |=> ##1 enum_info.bus_current_request == $past(wbyte, 2)) else $error("current wrong");
   vid_join_a: assert property (acc_wr && widx == IDX_VID_LOW[5:0]
      |=> ##1 enum_info.vendor_id[7:0] == $past(wbyte, 2)) else $error("vendor low wrong");
   pid_join_a: assert property (acc_wr && widx == IDX_PID_HIGH[5:0]
      |=> ##1 enum_info.product_id[15:8] == $past(wbyte, 2)) else $error("product high wrong");
   gpio_out_a: assert property (pin0_wr && wbyte[3:0] == 4'h0
      |=> ##1 pin_drive.oe[0] && pin_drive.out[0] == $past(wbyte[4], 2)) else $error("gpio out wrong");
   gpio_in_a: assert property (pin0_wr && wbyte[3:0] == 4'h8 |=> ##1 !pin_drive.oe[0])
      else $error("input pin driven");
   reserved_func_a: assert property (pin0_wr && wbyte[2:0] > 3'h2 |=> ##1 !pin_drive.oe[0])
      else $error("reserved code drives pin");
   load_first_a: assert property ($fell(rst) |-> !pin_drive.oe[0] [*4])
      else $error("pin driven before load");
endmodule : usb_identity_monitor

bind usb_identity_and_gp0_settings usb_identity_monitor u_usb_identity_monitor (.clk_sys(clk_sys), .rst(rst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .suspend_in(suspend_in), .rx_activity_in(rx_activity_in),
   .pin_in(pin_in), .pin_drive(pin_drive), .enum_info(enum_info));

// ==== usb_identity_pkg.sv ====
// constants, field layouts and carrier types of the usb identity and pin settings bank
// assumes a 32-bit apb slave at 125 mhz; one register per aligned word
package usb_identity_pkg;

   // printed offsets are byte indices, so byte address is index times four
   localparam logic [7:0] IDX_PIN0        = 8'h00;
   localparam logic [7:0] IDX_PIN1        = 8'h01;
   localparam logic [7:0] IDX_PIN2        = 8'h02;
   localparam logic [7:0] IDX_PIN3        = 8'h03;
   localparam logic [7:0] IDX_VID_LOW     = 8'h04;
   localparam logic [7:0] IDX_VID_HIGH    = 8'h05;
   localparam logic [7:0] IDX_PID_LOW     = 8'h06;
   localparam logic [7:0] IDX_PID_HIGH    = 8'h07;
   localparam logic [7:0] IDX_POWER_ATTR  = 8'h08;
   localparam logic [7:0] IDX_CURRENT_REQ = 8'h09;
   localparam logic [7:0] IDX_SECRET_BASE = 8'h0A;
   // nonvolatile image of the pin settings, indices 0x14..0x17
   // kept clear of the secret bytes and aligned so idx[1:0] picks the pin
   localparam logic [7:0] IDX_NV_PIN_BASE = 8'h14;
   // control: bit 0 reloads the working copy from the nonvolatile image
   localparam logic [7:0] IDX_CONTROL     = 8'h18;
   // status: enumeration words and load state
   localparam logic [7:0] IDX_ENUM_STATUS = 8'h19;
   localparam logic [7:0] IDX_PIN_STATUS  = 8'h1A;

   localparam int NUM_PINS    = 4;
   localparam int NUM_SECRETS = 8;

   // power attribute fields
   localparam int PWR_SELF_BIT = 6;
   localparam int PWR_WAKE_BIT = 5;
   localparam logic [7:0] PWR_ATTR_RESET   = 8'h80;
   localparam logic [7:0] CURRENT_RESET    = 8'h32;
   localparam logic [7:0] SECRET_RESET     = 8'h00;
   localparam logic [7:0] PIN0_RESET       = 8'h12;
   // other pins carry no documented layout here; plain defaults
   localparam logic [7:0] PINX_RESET       = 8'h00;

   // pin settings fields
   localparam int PIN_LEVEL_BIT = 4;
   localparam int PIN_DIR_BIT   = 3;
   localparam int PIN_FUNC_LSB  = 0;
   localparam logic [7:0] PIN_WRITE_MASK = 8'h1F;

   localparam int CTRL_RELOAD_BIT = 0;

   typedef enum logic [2:0] {
      FUNC_GENERAL = 3'h0,
      FUNC_SUSPEND = 3'h1,
      FUNC_RX_LED  = 3'h2
   } pin_func_e;

   typedef enum { LD_IDLE, LD_COPY, LD_DONE } load_state_e;

   // identity codes arbitrary, neutral values
   localparam logic [7:0] VID_LOW_RESET  = 8'h5A;
   localparam logic [7:0] VID_HIGH_RESET = 8'h1B;
   localparam logic [7:0] PID_LOW_RESET  = 8'h3C;
   localparam logic [7:0] PID_HIGH_RESET = 8'h02;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] product_id;
      logic        self_supplied_flag;
      logic        host_wake_capable;
      logic [7:0]  bus_current_request;
   } enum_info_s;

   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
   } pin_drive_s;

endpackage : usb_identity_pkg
